// ==== hw/ccp_cfg.svh ====
// Constants of the codec control-port slave: addresses, fields, resets.
// Assumes inclusion by the slave module only; holds definitions alone.
//
// Functional notes
// - SPI mode: all inputs, sampled on rising clock
// - SPI write opens with select low, address 0010000
// - No read-back and no data output in SPI
// - Then pointer byte, then data bytes to register
// - Increment flag: pointer holds or advances per byte
// - I2C: upper six 001000, LSB equals select pin
// - I2C direction bit: high reads, low writes
// - I2C write: first byte loads the pointer
// - I2C read drives selected register onto data
// - I2C auto-increment steps pointer per byte
// - I2C acknowledge after each byte, by receiver
// - Pointer: bit7 increment, 6-3 reserved, 2-0 select
// - Format pin high selects I2C, low SPI
// - Reset low clears all registers and port
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

// ****************************************************************
// Addresses and pointer layout
// ****************************************************************
`define CCP_SPI_CHIP_ADDR   7'h10
`define CCP_I2C_ADDR_HIGH   6'h08
`define CCP_PTR_AUTO_INCREMENT_FLAG_BIT    7
`define CCP_PTR_SEL_MSB     2
`define CCP_PTR_RESET       8'h00
`define CCP_REG_RESET       8'h00
`define CCP_REG_COUNT       8
`define CCP_LAST_BIT        3'h7
`define CCP_SYNC_PINS       4

`endif

// ==== hw/ccp_pkg.sv ====
// Types shared by the codec control-port slave.
// Assumes nothing of its surroundings.
package ccp_pkg;

	// ****************************************************************
	// Transfer states, one-hot
	// ****************************************************************
	typedef enum logic [7:0]
	{
		ST_IDLE  = 8'h01, // Waiting for select or start
		ST_ADDR  = 8'h02, // Chip address and direction byte
		ST_PTR   = 8'h04, // Pointer byte
		ST_WDATA = 8'h08, // Data bytes to registers
		ST_DACK  = 8'h10, // Device drives acknowledge
		ST_RDATA = 8'h20, // Device shifts out a register
		ST_HACK  = 8'h40, // Host answers a read byte
		ST_SKIP  = 8'h80  // Not addressed, wait for end
	} ccp_state_type;

endpackage

// ==== hw/ccp_slave.sv ====
// Serial control-port slave: SPI-style write-only or I2C with read-back.
// Assumes the host clock and data arrive asynchronously on pins and that
// the open-drain data wire is resolved outside from the enable.
`timescale 1ns/1ps
`include "ccp_cfg.svh"

module ccp_slave
(
	// Clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RESETN_IN,
	// Control pins
	input  wire logic        FORMAT_I2C_IN,
	input  wire logic        CTRL_SERIAL_CLOCK_IN,
	input  wire logic        CTRL_SERIAL_IN,
	input  wire logic        ADDR_SELECT_PIN_CS_N_IN,
	// Open-drain data drive
	output logic             CTRL_SERIAL_OUT,
	output logic             CTRL_SERIAL_OE_OUT,
	// Loaded settings
	output logic [63:0]      SETTINGS_OUT,
	output logic [7:0]       REG_POINTER_OUT
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [`CCP_SYNC_PINS-1:0] pin_raw;   // Raw pin levels
	logic [`CCP_SYNC_PINS-1:0] sync1;     // First stage, read by sync2 only
	logic [`CCP_SYNC_PINS-1:0] sync2;     // Second stage
	logic [`CCP_SYNC_PINS-1:0] sync3;     // Third stage
	logic [`CCP_SYNC_PINS-1:0] filt;      // Accepted level
	logic [`CCP_SYNC_PINS-1:0] filt_q;    // Level one cycle earlier
	logic [`CCP_SYNC_PINS-1:0] next_filt; // Next accepted level

	assign pin_raw = {FORMAT_I2C_IN, ADDR_SELECT_PIN_CS_N_IN,
		CTRL_SERIAL_IN, CTRL_SERIAL_CLOCK_IN};

	genvar gi;
	generate
		for (gi = 0; gi < `CCP_SYNC_PINS; gi++)
		begin : g_sync
			// A change counts only once stages two and three agree
			always_comb
			begin
				next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
			end

			// Three-stage chain plus accepted level
			always_ff @(posedge REF_CLK_IN)
			begin
				if (!RESETN_IN)
				begin
					sync1[gi]  <= 1'b0;
					sync2[gi]  <= 1'b0;
					sync3[gi]  <= 1'b0;
					filt[gi]   <= 1'b0;
					filt_q[gi] <= 1'b0;
				end
				else
				begin
					sync1[gi]  <= pin_raw[gi];
					sync2[gi]  <= sync1[gi];
					sync3[gi]  <= sync2[gi];
					filt[gi]   <= next_filt[gi];
					filt_q[gi] <= filt[gi];
				end
			end
		end
	endgenerate

	// Named views of the accepted levels
	logic is_i2c;   // Format select
	logic sel_pin;  // Address bit or chip select
	logic din;      // Serial data in
	logic clk_rise; // Host clock rising
	logic clk_fall; // Host clock falling
	logic i2c_start;
	logic i2c_stop;
	logic cs_fall;

	assign is_i2c    = filt[3];
	assign sel_pin   = filt[2];
	assign din       = filt[1];
	assign clk_rise  = filt[0] & ~filt_q[0];
	assign clk_fall  = ~filt[0] & filt_q[0];
	// Data moving while the clock stays high marks start or stop
	assign i2c_start = is_i2c & filt[0] & filt_q[0] & ~din & filt_q[1];
	assign i2c_stop  = is_i2c & filt[0] & filt_q[0] & din & ~filt_q[1];
	assign cs_fall   = ~is_i2c & ~sel_pin & filt_q[2];

	// ****************************************************************
	// Transfer engine and register file
	// ****************************************************************
	ccp_pkg::ccp_state_type state;      // Transfer state
	ccp_pkg::ccp_state_type next_state;
	ccp_pkg::ccp_state_type ack_next;   // State after an acknowledge
	ccp_pkg::ccp_state_type next_ack_next;
	logic [2:0] bit_cnt;                // Bits of the current byte
	logic [2:0] next_bit_cnt;
	logic [7:0] shreg;                  // Shift or read byte
	logic [7:0] next_shreg;
	logic       ack_on;                 // Acknowledge being driven
	logic       next_ack_on;
	logic       oe;                     // Pulls the data wire low
	logic       next_oe;
	logic [7:0] pointer;                // Register pointer
	logic [7:0] next_pointer;
	logic [7:0] regs [`CCP_REG_COUNT];  // Setting registers
	logic [7:0] next_regs [`CCP_REG_COUNT];
	logic [7:0] byte_in;                // Byte completed this edge
	logic [2:0] sel;                    // Register selected
	logic       auto_increment_flag;                   // Auto-increment flag
	logic       byte_done;              // Last bit of a byte sampled

	assign byte_in   = {shreg[6:0], din};
	assign sel       = pointer[`CCP_PTR_SEL_MSB:0];
	assign auto_increment_flag      = pointer[`CCP_PTR_AUTO_INCREMENT_FLAG_BIT];
	assign byte_done = clk_rise && (bit_cnt == `CCP_LAST_BIT);

	// Next values of the whole transfer engine
	always_comb
	begin
		logic load;
		load          = 1'b0;
		next_state    = state;
		next_ack_next = ack_next;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_ack_on   = ack_on;
		next_oe       = oe;
		next_pointer  = pointer;
		for (int i = 0; i < `CCP_REG_COUNT; i++)
		begin
			next_regs[i] = regs[i];
		end

		// Receiving states shift on every sampling edge
		if (clk_rise && (state == ccp_pkg::ST_ADDR
			|| state == ccp_pkg::ST_PTR || state == ccp_pkg::ST_WDATA))
		begin
			next_shreg   = byte_in;
			next_bit_cnt = bit_cnt + 3'h1;
		end

		case (state)
			ccp_pkg::ST_ADDR:
			begin
				// Chip address and direction decode
				if (byte_done)
				begin
					if (!is_i2c)
					begin
						// SPI accepts only a write to its address
						if (byte_in == {`CCP_SPI_CHIP_ADDR, 1'b0})
							next_state = ccp_pkg::ST_PTR;
						else
							next_state = ccp_pkg::ST_SKIP;
					end
					else if (byte_in[7:2] == `CCP_I2C_ADDR_HIGH
						&& byte_in[1] == sel_pin)
					begin
						next_state    = ccp_pkg::ST_DACK;
						next_ack_next = byte_in[0] ? ccp_pkg::ST_HACK
							: ccp_pkg::ST_PTR;
					end
					else
						next_state = ccp_pkg::ST_SKIP;
				end
			end
			ccp_pkg::ST_PTR:
			begin
				// Pointer byte, reserved bits kept at zero
				if (byte_done)
				begin
					next_pointer = byte_in & 8'h87;
					next_state    = is_i2c ? ccp_pkg::ST_DACK
						: ccp_pkg::ST_WDATA;
					next_ack_next = ccp_pkg::ST_WDATA;
				end
			end
			ccp_pkg::ST_WDATA:
			begin
				// Data byte lands in the selected register
				if (byte_done)
				begin
					next_regs[sel] = byte_in;
					if (auto_increment_flag)
						next_pointer[2:0] = sel + 3'h1;
					next_state    = is_i2c ? ccp_pkg::ST_DACK
						: ccp_pkg::ST_WDATA;
					next_ack_next = ccp_pkg::ST_WDATA;
				end
			end
			ccp_pkg::ST_DACK:
			begin
				// Pull low for the ninth clock, release after it
				if (clk_fall)
				begin
					if (!ack_on)
					begin
						next_ack_on = 1'b1;
						next_oe     = 1'b1;
					end
					else
					begin
						next_ack_on = 1'b0;
						next_oe     = 1'b0;
						next_state  = ack_next;
						// Read direction: first data bit follows at once
						load = (ack_next == ccp_pkg::ST_HACK);
					end
				end
			end
			ccp_pkg::ST_RDATA:
			begin
				// Bits change on falling edges, host samples on rising
				if (clk_rise)
					next_bit_cnt = bit_cnt + 3'h1;
				if (clk_fall)
				begin
					if (bit_cnt == 3'h0)
					begin
						next_oe    = 1'b0; // Host drives acknowledge
						next_state = ccp_pkg::ST_HACK;
						if (auto_increment_flag)
							next_pointer[2:0] = sel + 3'h1;
					end
					else
						next_oe = ~shreg[3'h7 - bit_cnt];
				end
			end
			ccp_pkg::ST_HACK:
			begin
				// Host acknowledge continues the read, else give up
				if (clk_rise)
					next_state = din ? ccp_pkg::ST_SKIP : ccp_pkg::ST_RDATA;
				if (clk_rise && !din)
					next_bit_cnt = 3'h7; // Marks a pending load
				if (clk_fall && bit_cnt == 3'h7)
					load = 1'b1;
			end
			ccp_pkg::ST_IDLE,
			ccp_pkg::ST_SKIP:
			begin
				next_oe = 1'b0;
			end
			default:
			begin
				next_state = ccp_pkg::ST_IDLE;
			end
		endcase

		// Read load: state returns to sending at bit 7
		if (load)
		begin
			next_shreg   = regs[sel];
			next_oe      = ~regs[sel][7];
			next_bit_cnt = 3'h0;
			next_state   = ccp_pkg::ST_RDATA;
		end
		// Host acknowledge turns back into sending only via load
		if (state == ccp_pkg::ST_HACK && next_state == ccp_pkg::ST_RDATA
			&& !load)
			next_state = ccp_pkg::ST_HACK;

		// Framing events win over everything inside a byte
		if (!is_i2c)
		begin
			next_oe = 1'b0;
			if (sel_pin)
			begin
				next_state   = ccp_pkg::ST_IDLE;
				next_bit_cnt = 3'h0;
			end
			else if (cs_fall)
			begin
				next_state   = ccp_pkg::ST_ADDR;
				next_bit_cnt = 3'h0;
			end
		end
		else if (i2c_start)
		begin
			next_state   = ccp_pkg::ST_ADDR;
			next_bit_cnt = 3'h0;
			next_ack_on  = 1'b0;
			next_oe      = 1'b0;
		end
		else if (i2c_stop)
		begin
			next_state   = ccp_pkg::ST_IDLE;
			next_bit_cnt = 3'h0;
			next_ack_on  = 1'b0;
			next_oe      = 1'b0;
		end
	end

	// Registers of the transfer engine
	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RESETN_IN)
		begin
			state    <= ccp_pkg::ST_IDLE;
			ack_next <= ccp_pkg::ST_IDLE;
			bit_cnt  <= 3'h0;
			shreg    <= 8'h00;
			ack_on   <= 1'b0;
			oe       <= 1'b0;
			pointer  <= `CCP_PTR_RESET;
			for (int i = 0; i < `CCP_REG_COUNT; i++)
				regs[i] <= `CCP_REG_RESET;
		end
		else
		begin
			state    <= next_state;
			ack_next <= next_ack_next;
			bit_cnt  <= next_bit_cnt;
			shreg    <= next_shreg;
			ack_on   <= next_ack_on;
			oe       <= next_oe;
			pointer  <= next_pointer;
			for (int i = 0; i < `CCP_REG_COUNT; i++)
				regs[i] <= next_regs[i];
		end
	end

	// ****************************************************************
	// Outputs, straight from flip-flops except the constant data level
	// ****************************************************************
	assign CTRL_SERIAL_OUT    = 1'b0; // Open drain only ever pulls low
	assign CTRL_SERIAL_OE_OUT = oe;
	assign REG_POINTER_OUT    = pointer;
	generate
		for (gi = 0; gi < `CCP_REG_COUNT; gi++)
		begin : g_out
			assign SETTINGS_OUT[gi*8 +: 8] = regs[gi];
		end
	endgenerate

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	sequence spi_bad_addr_s;
		!is_i2c && !sel_pin && state == ccp_pkg::ST_ADDR && byte_done
			&& byte_in != {`CCP_SPI_CHIP_ADDR, 1'b0};
	endsequence
	sequence i2c_ack_start_s;
		is_i2c && state == ccp_pkg::ST_DACK && clk_fall && !ack_on
			&& !i2c_start && !i2c_stop;
	endsequence

	spi_no_drive_a: assert property (!is_i2c |=> !oe)
		else $error("data driven in SPI mode");
	spi_addr_check_a: assert property (spi_bad_addr_s |=>
		state == ccp_pkg::ST_SKIP)
		else $error("SPI wrong address accepted");
	spi_abort_a: assert property (!is_i2c && sel_pin |=>
		state == ccp_pkg::ST_IDLE && bit_cnt == 3'h0)
		else $error("SPI transfer not abandoned");
	ptr_reserved_a: assert property (pointer[6:3] == 4'h0)
		else $error("reserved pointer bits set");
	ptr_hold_a: assert property (state == ccp_pkg::ST_WDATA && byte_done
		&& !auto_increment_flag |=> pointer == $past(pointer))
		else $error("pointer moved without increment");
	ptr_step_a: assert property (state == ccp_pkg::ST_WDATA && byte_done
		&& auto_increment_flag |=> pointer[2:0] == $past(pointer[2:0]) + 3'h1)
		else $error("pointer did not advance");
	write_lands_a: assert property (state == ccp_pkg::ST_WDATA
		&& byte_done |=> regs[$past(sel)] == $past(byte_in))
		else $error("data byte not stored");
	ack_drive_a: assert property (i2c_ack_start_s |=> oe)
		else $error("acknowledge not driven");
	// Own disable term: the default one would mute this check in reset
	reset_clear_a: assert property (@(posedge REF_CLK_IN)
		disable iff (1'b0)
		!RESETN_IN |=> pointer == `CCP_PTR_RESET && !oe)
		else $error("reset did not clear port");

endmodule // ccp_slave

// ==== sim/ccp_host.sv ====
// Behavioural host master for both control-port formats.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps

module ccp_host
(
	// System clock for bit timing
	input  wire logic clk_in,
	// Resolved data wire
	input  wire logic sda_line_in,
	// Host pins
	output logic      scl_out,
	output logic      sda_out,
	output logic      cs_n_out
);
	// ****
	// Bit timing
	// ****
	// Half of a 160 ns link period, in 5 ns cycles
	localparam int HALF = 16;

	// Idle: clock low and still, data released, deselected
	initial
	begin
		scl_out  = 1'b0;
		sda_out  = 1'b1;
		cs_n_out = 1'b1;
	end

	// Step just past a system edge so pins never race the sampler
	task automatic wait_cyc(input int n);
	begin
		repeat (n) @(posedge clk_in);
		#1;
	end
	endtask

	// Data moves mid-way through the low phase, held across rising edge;
	// low and high phases of HALF each give the 160 ns bit period
	task automatic tx_bit(input logic b, output logic s);
	begin
		sda_out = b;
		wait_cyc(HALF / 2);
		scl_out = 1'b1;
		wait_cyc(HALF);
		s = sda_line_in;
		scl_out = 1'b0;
		wait_cyc(HALF / 2);
	end
	endtask

	// Whole byte, MSB first; the seen wire level comes back
	task automatic tx_byte(input logic [7:0] w, output logic [7:0] r);
		int i;
	begin
		for (i = 7; i >= 0; i--)
			tx_bit(w[i], r[i]);
	end
	endtask

	// Byte then released acknowledge slot; ack high when pulled low
	task automatic i2c_wbyte(input logic [7:0] w, output logic ack);
		logic [7:0] r;
		logic       s;
	begin
		tx_byte(w, r);
		tx_bit(1'b1, s);
		ack = !s;
	end
	endtask

	// Read byte with data released; host answers ack or not
	task automatic i2c_rbyte(input logic last, output logic [7:0] r);
		logic s;
	begin
		tx_byte(8'hff, r);
		tx_bit(last, s);
	end
	endtask

	// Start, also usable as repeated start
	task automatic i2c_start();
	begin
		sda_out = 1'b1;
		wait_cyc(HALF);
		scl_out = 1'b1;
		wait_cyc(HALF);
		sda_out = 1'b0;
		wait_cyc(HALF);
		scl_out = 1'b0;
		wait_cyc(HALF / 2);
	end
	endtask

	// Stop leaves the bus idle with both lines high
	task automatic i2c_stop();
	begin
		sda_out = 1'b0;
		wait_cyc(HALF);
		scl_out = 1'b1;
		wait_cyc(HALF);
		sda_out = 1'b1;
		wait_cyc(HALF);
	end
	endtask

	// Select low opens a frame
	task automatic spi_begin();
	begin
		scl_out = 1'b0;
		cs_n_out = 1'b0;
		wait_cyc(HALF);
	end
	endtask

	// No pull-up in this format: released data shows the inverse
	task automatic spi_end();
	begin
		cs_n_out = 1'b1;
		sda_out = !sda_out;
		wait_cyc(HALF);
	end
	endtask

	// Address pin level in the two-wire format
	task automatic set_sel(input logic v);
	begin
		cs_n_out = v;
	end
	endtask
endmodule // ccp_host

// ==== sim/test_ccp_slave.sv ====
// Bench of the control-port slave: host model, expectations, checks.
// Assumes the design and the host model are compiled first.
`timescale 1ns/1ps

`define CHK(what, exp, got) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end

module test_ccp_slave;
	// Clock, reset, pins and expectation state
	logic        ref_clk;
	logic        resetn;
	logic        format_i2c;
	logic        scl;
	logic        host_sda;
	logic        host_sel;
	logic        sda_line;
	logic        ser_out;
	logic        ser_oe;
	logic [63:0] settings;
	logic [7:0]  pointer;
	logic [7:0]  exp_regs [8];
	logic [7:0]  exp_ptr;
	logic        sel_pin;
	logic        spi_oe_seen;
	logic [31:0] seed;
	int          mismatches;
	int          compares;

	// Open drain with pull-up: the device can only pull low
	assign sda_line = host_sda & (ser_oe ? ser_out : 1'b1);

	// Design under test
	ccp_slave ccp_slave_inst
	(
		.REF_CLK_IN              (ref_clk),
		.RESETN_IN               (resetn),
		.FORMAT_I2C_IN           (format_i2c),
		.CTRL_SERIAL_CLOCK_IN    (scl),
		.CTRL_SERIAL_IN          (sda_line),
		.ADDR_SELECT_PIN_CS_N_IN (host_sel),
		.CTRL_SERIAL_OUT         (ser_out),
		.CTRL_SERIAL_OE_OUT      (ser_oe),
		.SETTINGS_OUT            (settings),
		.REG_POINTER_OUT         (pointer)
	);

	// Host partner
	ccp_host ccp_host_inst
	(
		.clk_in      (ref_clk),
		.sda_line_in (sda_line),
		.scl_out     (scl),
		.sda_out     (host_sda),
		.cs_n_out    (host_sel)
	);

	// 200 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Any drive in the write-only format is a fault
	always @(posedge ref_clk)
		if (!resetn)
			spi_oe_seen <= 1'b0;
		else if (!format_i2c && ser_oe === 1'b1)
			spi_oe_seen <= 1'b1;

	// ****
	// Expectation helpers
	// ****
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	// Reserved pointer bits never stick
	function automatic logic [7:0] ptr_load(input logic [7:0] b);
		return {b[7], 4'h0, b[2:0]};
	endfunction

	// Flag set: step within the select field
	function automatic logic [7:0] ptr_step(input logic [7:0] p);
		return p[7] ? {p[7], 4'h0, p[2:0] + 3'h1} : p;
	endfunction

	function automatic logic [63:0] pack();
		logic [63:0] v;
		for (int i = 0; i < 8; i++)
			v[8*i +: 8] = exp_regs[i];
		return v;
	endfunction

	task automatic wait_cyc(input int n);
	begin
		repeat (n) @(posedge ref_clk);
		#1;
	end
	endtask

	task automatic check_state();
	begin
		wait_cyc(8);
		`CHK("settings", pack(), settings)
		`CHK("pointer", exp_ptr, pointer)
	end
	endtask

	// Write-only frame; takes effect only with 0x20 in that format
	task automatic spi_write(input logic [7:0] a, input logic [7:0] p,
		input int n);
		logic [7:0] r;
		logic [7:0] d;
		logic       ok;
	begin
		ok = (a === 8'h20) && !format_i2c;
		ccp_host_inst.spi_begin();
		ccp_host_inst.tx_byte(a, r);
		ccp_host_inst.tx_byte(p, r);
		if (ok)
			exp_ptr = ptr_load(p);
		for (int i = 0; i < n; i++)
		begin
			d = rnd();
			ccp_host_inst.tx_byte(d, r);
			if (ok)
			begin
				exp_regs[exp_ptr[2:0]] = d;
				exp_ptr = ptr_step(exp_ptr);
			end
		end
		ccp_host_inst.spi_end();
		check_state();
	end
	endtask

	// Two-wire write; ack expected only on a matching address
	task automatic i2c_write(input logic [7:0] a, input logic [7:0] p,
		input int n, input logic stp);
		logic       ack;
		logic       hit;
		logic [7:0] d;
	begin
		hit = a[7:2] == 6'b001000 && a[1] == sel_pin && !a[0];
		ccp_host_inst.i2c_start();
		ccp_host_inst.i2c_wbyte(a, ack);
		`CHK("addr_ack", hit, ack)
		if (hit)
		begin
			ccp_host_inst.i2c_wbyte(p, ack);
			`CHK("ptr_ack", 1'b1, ack)
			exp_ptr = ptr_load(p);
			for (int i = 0; i < n; i++)
			begin
				d = rnd();
				ccp_host_inst.i2c_wbyte(d, ack);
				`CHK("data_ack", 1'b1, ack)
				exp_regs[exp_ptr[2:0]] = d;
				exp_ptr = ptr_step(exp_ptr);
			end
		end
		if (stp)
			ccp_host_inst.i2c_stop();
		check_state();
	end
	endtask

	// Two-wire read after repeated start; last byte is not acked
	task automatic i2c_read(input logic [7:0] a, input int n);
		logic       ack;
		logic [7:0] r;
	begin
		ccp_host_inst.i2c_start();
		ccp_host_inst.i2c_wbyte(a, ack);
		`CHK("read_ack", 1'b1, ack)
		for (int i = 0; i < n; i++)
		begin
			ccp_host_inst.i2c_rbyte(i == n - 1, r);
			`CHK("read_data", exp_regs[exp_ptr[2:0]], r)
			exp_ptr = ptr_step(exp_ptr);
		end
		ccp_host_inst.i2c_stop();
		check_state();
		`CHK("released", 1'b0, ser_oe)
	end
	endtask

	task automatic wrap_up();
	begin
		$display("Counts: %0d compares, %0d mismatches", compares,
			mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	// Watchdog: about three times the expected run
	initial
	begin
		#300us;
		mismatches++;
		wrap_up();
	end

	// ****
	// Main sequence
	// ****
	initial
	begin
		logic s;
		resetn = 1'b0;
		format_i2c = 1'b0;
		seed = 32'd56;
		sel_pin = 1'b1;
		exp_ptr = 8'h00;
		mismatches = 0;
		compares = 0;
		for (int i = 0; i < 8; i++)
			exp_regs[i] = 8'h00;
		repeat (16) @(posedge ref_clk);
		#1 resetn = 1'b1;
		wait_cyc(8);
		check_state();
		`CHK("reset_oe", 1'b0, ser_oe)
		$display("Test reset done");
		spi_write(8'h20, 8'hfb, 3);
		spi_write(8'h20, 8'h87, 2);
		spi_write(8'h20, 8'h01, 2);
		spi_write(8'h21, 8'h02, 1);
		spi_write(8'h22, 8'h02, 1);
		spi_write(8'ha0, 8'h02, 1);
		for (int k = 0; k < 3; k++)
			spi_write(8'h20, rnd(), 2);
		// Partial byte then a clean frame must realign
		ccp_host_inst.spi_begin();
		for (int i = 0; i < 4; i++)
			ccp_host_inst.tx_bit(1'b1, s);
		ccp_host_inst.spi_end();
		spi_write(8'h20, 8'h02, 1);
		$display("Test spi done");
		format_i2c = 1'b1;
		ccp_host_inst.set_sel(1'b1);
		wait_cyc(8);
		i2c_write(8'h20, 8'h00, 1, 1'b1);
		i2c_write(8'h32, 8'h00, 1, 1'b1);
		i2c_write(8'h22, 8'h86, 3, 1'b1);
		i2c_write(8'h22, 8'h80, 0, 1'b0);
		i2c_read(8'h23, 8);
		sel_pin = 1'b0;
		ccp_host_inst.set_sel(1'b0);
		wait_cyc(8);
		i2c_write(8'h20, 8'h05, 1, 1'b0);
		i2c_read(8'h21, 2);
		spi_write(8'h20, 8'h03, 1);
		$display("Test i2c done");
		format_i2c = 1'b0;
		wait_cyc(8);
		spi_write(8'h20, 8'h04, 1);
		`CHK("spi_no_drive", 1'b0, spi_oe_seen)
		$display("Test format done");
		// Reset in mid-run must clear settings that are no longer zero
		wait_cyc(1);
		resetn = 1'b0;
		wait_cyc(4);
		resetn = 1'b1;
		exp_ptr = 8'h00;
		for (int i = 0; i < 8; i++)
			exp_regs[i] = 8'h00;
		wait_cyc(8);
		check_state();
		`CHK("mid_reset_oe", 1'b0, ser_oe)
		$display("Test mid reset done");
		wrap_up();
	end
endmodule // test_ccp_slave
